//--- sbp_regs.svh
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH

// Geometry of one access: four bytes of nine bits, ninth bit is parity.
`define SBP_BYTES        4
`define SBP_BYTE_W       9
`define SBP_WORD_W       36
`define SBP_PAR_BIT      8

// Strap levels seen before the synchronisers fill (internal pulls).
`define SBP_RST_IO_EN    1'b0
`define SBP_RST_SENSE    1'b1
`define SBP_RST_FLOW     1'b1

// Strap encodings.
`define SBP_SENSE_EVEN   1'b1
`define SBP_SEL_FLOW     1'b0

// Error latency in cycles after the data cycle.
`define SBP_RD_LAT       1
`define SBP_FT_WR_LAT    1
`define SBP_PL_WR_LAT    2

`endif

//--- sbp_pkg.sv
package sbp_pkg;
  typedef logic [8:0]  sbp_byte_t;
  typedef logic [35:0] sbp_word_t;
  typedef logic [3:0]  sbp_lane_t;
  typedef enum logic {
    SBP_MODE_EXT = 1'b0,
    SBP_MODE_INT = 1'b1
  } sbp_mode_t;
endpackage

//--- sbp_byte_if.sv
interface sbp_byte_if;
  import sbp_pkg::*;
  sbp_byte_t byte_data;
  logic      sense;
  logic      gen_par;
  logic      mismatch;
  modport chk  (input byte_data, input sense, output gen_par, output mismatch);
  modport user (output byte_data, output sense, input gen_par, input mismatch);
endinterface

//--- sbp_byte_parity.sv
module sbp_byte_parity (
  // Byte under test and its result
  sbp_byte_if.chk bif
);
  import sbp_pkg::*;

  // Parity bit that makes the eight data bits meet the selected sense.
  assign bif.gen_par  = (^bif.byte_data[7:0]) ^ ~bif.sense;
  // Even sense wants an even count of ones over nine bits, odd wants odd.
  assign bif.mismatch = ((^bif.byte_data) == bif.sense);
endmodule

//--- sbp_parity.sv
// Overview of operation
// - Strap low: ninth I/O active; high: internal only
// - Internal mode: generate and store parity per byte
// - Internal mode: check reads, error next cycle
// - Internal mode: never drive ninth data output
// - External mode: check byte-enabled written bytes with ninth
// - Flow-through: write error one cycle after data
// - Pipelined: write error two cycles after data
// - Sense strap high even, low odd parity
// - External mode: read data is never checked
// - Open-drain error pulled low, released otherwise
`include "sbp_regs.svh"

module sbp_parity (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // Mode straps from pins
  input  wire logic              parity_io_enable_strap,
  input  wire logic              parity_sense_select,
  input  wire logic              flow_or_pipeline_select,
  // Write path from the input registers
  input  wire logic              wr_valid,
  input  wire sbp_pkg::sbp_lane_t wr_byte_en,
  input  wire sbp_pkg::sbp_word_t wr_data,
  output sbp_pkg::sbp_word_t     array_wr_data,
  // Read path from the array
  input  wire logic              rd_valid,
  input  wire sbp_pkg::sbp_word_t array_rd_data,
  input  wire logic              rd_out_en,
  // Ninth data bit pins
  output sbp_pkg::sbp_lane_t     dq9_out,
  output sbp_pkg::sbp_lane_t     dq9_oe,
  // Open-drain parity error pin
  output logic                   parity_error_out_n,
  output logic                   parity_error_out_n_oe
);
  import sbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers.
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  sbp_mode_t  internal_parity_width_mode;
  logic       external_parity_width_mode;
  logic       sense_even;
  logic       flow_mode;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_meta <= {`SBP_RST_FLOW, `SBP_RST_SENSE, `SBP_RST_IO_EN};
      strap_sync <= {`SBP_RST_FLOW, `SBP_RST_SENSE, `SBP_RST_IO_EN};
    end else begin
      strap_meta <= {flow_or_pipeline_select, parity_sense_select, parity_io_enable_strap};
      strap_sync <= strap_meta;
    end
  end

  assign internal_parity_width_mode = strap_sync[0] ? SBP_MODE_INT : SBP_MODE_EXT;
  assign external_parity_width_mode = (internal_parity_width_mode == SBP_MODE_EXT);
  assign sense_even = (strap_sync[1] == `SBP_SENSE_EVEN);
  assign flow_mode  = (strap_sync[2] == `SBP_SEL_FLOW);

  ////////////////////////////////////////////////////////////////////////////
  // Per-byte parity checkers, one for write data and one for read data.
  sbp_lane_t wr_mism;
  sbp_lane_t rd_mism;
  sbp_lane_t gen_par;

  generate
    for (genvar i = 0; i < `SBP_BYTES; i++) begin : g_byte
      sbp_byte_if wr_if ();
      sbp_byte_if rd_if ();
      assign wr_if.byte_data = wr_data[i*`SBP_BYTE_W +: `SBP_BYTE_W];
      assign wr_if.sense     = sense_even;
      assign rd_if.byte_data = array_rd_data[i*`SBP_BYTE_W +: `SBP_BYTE_W];
      assign rd_if.sense     = sense_even;
      sbp_byte_parity u_wr (.bif(wr_if));
      sbp_byte_parity u_rd (.bif(rd_if));
      assign wr_mism[i] = wr_if.mismatch;
      assign rd_mism[i] = rd_if.mismatch;
      assign gen_par[i] = wr_if.gen_par;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Array write data: generated parity in internal mode, pin parity otherwise.
  sbp_word_t next_array_wr;

  always_comb begin
    next_array_wr = wr_data;
    for (int i = 0; i < `SBP_BYTES; i++) begin
      if (internal_parity_width_mode == SBP_MODE_INT) begin
        next_array_wr[i*`SBP_BYTE_W + `SBP_PAR_BIT] = gen_par[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      array_wr_data <= 36'h0_0000_0000;
    end else if (wr_valid) begin
      array_wr_data <= next_array_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ninth output bit. Internal mode keeps it undriven so a board that left
  // those balls open or tied sees no contention.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dq9_out <= 4'h0;
    end else if (rd_valid) begin
      for (int i = 0; i < `SBP_BYTES; i++) begin
        dq9_out[i] <= array_rd_data[i*`SBP_BYTE_W + `SBP_PAR_BIT];
      end
    end
  end

  assign dq9_oe = (external_parity_width_mode && rd_out_en) ? 4'hF : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Error detection and latency alignment.
  logic rd_err_now;
  logic wr_err_now;
  logic wr_err_s1;
  logic next_err;
  logic err_oe;

  // Only enabled lanes of a write are judged; every lane of a read is.
  assign wr_err_now = wr_valid && external_parity_width_mode
                      && |(wr_byte_en & wr_mism);
  assign rd_err_now = rd_valid && (internal_parity_width_mode == SBP_MODE_INT)
                      && |rd_mism;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_err_s1 <= 1'b0;
    end else begin
      wr_err_s1 <= wr_err_now;
    end
  end

  // Causes that land in the same cycle merge into one low pulse.
  assign next_err = rd_err_now || (flow_mode ? wr_err_now : wr_err_s1);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      err_oe <= 1'b0;
    end else begin
      err_oe <= next_err;
    end
  end

  assign parity_error_out_n    = 1'b0;
  assign parity_error_out_n_oe = err_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic [3:0] stored_bad;
  logic       sense_q;
  logic       int_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sense_q <= 1'b0;
      int_q   <= 1'b0;
    end else begin
      sense_q <= sense_even;
      int_q   <= (internal_parity_width_mode == SBP_MODE_INT);
    end
  end

  always_comb begin
    for (int i = 0; i < `SBP_BYTES; i++) begin
      stored_bad[i] = ((^array_wr_data[i*`SBP_BYTE_W +: `SBP_BYTE_W]) == sense_q);
    end
  end

  a_gen_stored_ok: assert property (
    wr_valid && internal_parity_width_mode == SBP_MODE_INT |=> int_q && stored_bad == 4'h0)
    else $error("stored parity does not meet selected sense");

  a_rd_err_latency: assert property (
    rd_valid && internal_parity_width_mode == SBP_MODE_INT && rd_mism != 4'h0
    |=> parity_error_out_n_oe)
    else $error("read parity error not flagged next cycle");

  a_no_dq9_internal: assert property (
    internal_parity_width_mode == SBP_MODE_INT |-> dq9_oe == 4'h0)
    else $error("ninth output driven in internal mode");

  a_dq9_external: assert property (
    external_parity_width_mode && rd_out_en |-> dq9_oe == 4'hF)
    else $error("ninth output not driven in external mode");

  a_ft_wr_latency: assert property (
    wr_valid && external_parity_width_mode && flow_mode && (wr_byte_en & wr_mism) != 4'h0
    |=> parity_error_out_n_oe)
    else $error("flow-through write error not flagged after one cycle");

  a_pl_wr_latency: assert property (
    wr_valid && external_parity_width_mode && !flow_mode && (wr_byte_en & wr_mism) != 4'h0
    ##1 !flow_mode |=> parity_error_out_n_oe)
    else $error("pipelined write error not flagged after two cycles");

  a_no_rd_check_ext: assert property (
    external_parity_width_mode && !wr_err_now && !(!flow_mode && wr_err_s1)
    |=> !parity_error_out_n_oe)
    else $error("error flagged without a write parity fault");

  a_err_one_cycle: assert property (
    rd_err_now ##1 (!rd_err_now && !wr_err_now && !wr_err_s1) |=> !parity_error_out_n_oe)
    else $error("error pulse longer than one cycle");

  a_od_low_only: assert property (
    parity_error_out_n_oe |-> parity_error_out_n == 1'b0)
    else $error("open-drain output drives high");

  c_rd_error: cover property (rd_err_now ##1 parity_error_out_n_oe);
  c_ft_wr_error: cover property (flow_mode && wr_err_now ##1 parity_error_out_n_oe);
  c_pl_wr_error: cover property (!flow_mode && wr_err_now ##2 parity_error_out_n_oe);
endmodule

//--- sbp_ctl_model.sv
module sbp_ctl_model (
  // Clock
  input  wire logic               sys_clk,
  // Array side of the parity block
  input  wire logic               wr_valid,
  input  wire logic [1:0]         wr_addr,
  input  wire sbp_pkg::sbp_word_t array_wr_data,
  input  wire logic [1:0]         rd_addr,
  input  wire logic               corrupt,
  output sbp_pkg::sbp_word_t      array_rd_data,
  // Shared open-drain error line
  input  wire logic               err_oe,
  output logic                    err_line
);
  import sbp_pkg::*;
  sbp_word_t  mem [4];
  logic       stored;
  logic [1:0] st_addr;
  // The array word lands one edge after the write, when the block has registered it.
  always_ff @(posedge sys_clk) begin
    stored  <= wr_valid;
    st_addr <= wr_addr;
    if (stored) begin
      mem[st_addr] <= array_wr_data;
    end
  end
  // A flip on lane 0 stands in for an array upset, and only when the bench asks.
  assign array_rd_data = mem[rd_addr] ^ {35'h0, corrupt};
  // The pull-up wins whenever no device pulls the line low.
  assign err_line = err_oe ? 1'b0 : 1'b1;
endmodule

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbp_pkg::*;
  logic       sys_clk = 0, reset_n = 0, pe = 0, sense = 1, flow = 0;
  logic       wr_valid = 0, rd_valid = 0, rd_out_en = 0, corrupt = 0;
  logic       err_line, err_oe, err_n;
  logic [1:0] wr_addr = 0, rd_addr = 0;
  sbp_lane_t  wr_byte_en = 0, dq9_out, dq9_oe;
  sbp_word_t  wr_data = 0, array_wr_data, array_rd_data, shadow [4];
  int         cyc = 0, mismatches = 0, samples_checked = 0;
  int         exp_q [$];

  sbp_parity u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .parity_io_enable_strap(pe),
    .parity_sense_select(sense), .flow_or_pipeline_select(flow), .wr_valid(wr_valid),
    .wr_byte_en(wr_byte_en), .wr_data(wr_data), .array_wr_data(array_wr_data),
    .rd_valid(rd_valid), .array_rd_data(array_rd_data), .rd_out_en(rd_out_en),
    .dq9_out(dq9_out), .dq9_oe(dq9_oe), .parity_error_out_n(err_n),
    .parity_error_out_n_oe(err_oe));
  sbp_ctl_model u_ctl (.sys_clk(sys_clk), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .array_wr_data(array_wr_data), .rd_addr(rd_addr), .corrupt(corrupt),
    .array_rd_data(array_rd_data), .err_oe(err_oe), .err_line(err_line));

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  //////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Every low cycle of the shared line must match the oldest note.
  always @(negedge sys_clk) begin
    if (reset_n && err_line === 1'b0) begin
      chk("error_cycle", cyc, exp_q.size() ? exp_q.pop_front() : 0);
    end
  end

  task idle(input int n);
    wr_valid = 0;
    rd_valid = 0;
    corrupt  = 0;
    repeat (n) @(negedge sys_clk);
  endtask

  // Straps are meant to be static, so traffic drains before and after a change.
  task set_mode(input logic p, input logic s, input logic f);
    idle(4);
    pe    = p;
    sense = s;
    flow  = f;
    idle(4);
  endtask

  task wr(input logic [1:0] a, input sbp_lane_t be, input int bad, input bit exp);
    sbp_word_t gw, w;
    for (int i = 0; i < 4; i++) begin
      gw[9*i +: 8] = $urandom;
      gw[9*i+8]    = ^gw[9*i +: 8] ^ ~sense;
    end
    w = gw;
    if (bad >= 0) w[9*bad+8] = ~w[9*bad+8];
    wr_valid   = 1;
    wr_addr    = a;
    wr_byte_en = be;
    wr_data    = w;
    shadow[a]  = pe ? gw : w;
    if (exp) exp_q.push_back(cyc + 1 + flow);
    @(negedge sys_clk);
    if (be == 4'hF) chk("array_wr_data", array_wr_data, shadow[a]);
  endtask

  task rd(input logic [1:0] a, input bit c, input bit exp);
    rd_valid  = 1;
    rd_addr   = a;
    corrupt   = c;
    rd_out_en = $urandom;
    #1 chk("dq9_oe", dq9_oe, (!pe && rd_out_en) ? 4'hF : 4'h0);
    if (exp) exp_q.push_back(cyc + 1);
    @(negedge sys_clk);
    chk("dq9_out", dq9_out, {shadow[a][35], shadow[a][26], shadow[a][17], shadow[a][8]});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0d18_cbb3));
    repeat (4) @(negedge sys_clk);
    reset_n = 1;
    for (int m = 0; m < 6; m++) begin
      set_mode(m > 3, m[0], m[1] && m < 4);
      if (m < 4) begin
        wr(0, 4'hF, -1, 0);
        wr(0, 4'hF, m, 1);
        wr(3, ~(4'h1 << m), m, 0);
        wr(3, 4'hF, 3 - m, 1);
        wr(3, 4'hF, 0, 1);
        idle(4);
        rd(0, 1, 0);
      end else begin
        // Every word is written before any read of it.
        for (int a = 0; a < 4; a++) begin
          wr(a, 4'hF, a, 0);
        end
        idle(2);
        for (int a = 0; a < 4; a++) begin
          rd(a, 0, 0);
        end
        rd(1, 1, 1);
        rd(2, 1, 1);
      end
      idle(4);
    end
    chk("pending_errors", exp_q.size(), 0);
    chk("error_pin_level", err_n, 0);
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop;
  end
endmodule
